// ---- logic/vic_classifier.sv ----
// Purpose: VLAN ingress classification with APB configuration
// Assumes: Packet inputs come from logic on ref_clk; one result per in_valid
// Notes: Result appears on the cycle after in_valid
// Operation
// - Control bit selects tag or port VLAN
// - Sixteen filters with valid, VID, group, masks
// - Port mode indexes filters 0-5 by port
// - Tag mode matches VID over all filters, or over filters 6-15 only with fallback
// - Optionally replace VID zero with port VID
// - Optionally replace VID one with port VID
// - Optionally replace all-ones VID with port VID
// - Security active uses port VID only
// - Forced untagged input uses port VID
// - Unreplaced all-ones VID under security violates
// - Tagged-only port rejects untagged or null VID
// - Forced untagged disables tagged-only check
// - Unmatched VID with checking violates
// - Group from filter, else default group
// - Fallback resolves unmatched packets by port filters
// - Unmatched without fallback uses default portmap
// - Ingress filter rejects source outside boundary
// - Violations drop unless cross-VLAN
// - Each packet gets 2-bit egress tag control
// - Bridge-group class: override, learning, control, config
// - ARP class: override then config
// - IGMP class: override then config
// - Others: override, learning hit, else zero
`timescale 1ns/1ps
module vic_classifier (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_valid,
  input wire logic [2:0] in_src_port,
  input wire logic in_tagged,
  input wire logic [11:0] in_tag_vid,
  input wire vic_pkg::vic_cls_t in_class,
  input wire logic in_cross_vlan,
  input wire logic tag_override_valid,
  input wire logic [1:0] tag_override,
  input wire logic lrn_hit,
  input wire logic [1:0] lrn_tag,
  input wire logic ctl_hit,
  input wire logic [1:0] ctl_tag,
  output logic out_valid,
  output logic out_drop,
  output logic out_violation,
  output logic [3:0] out_group,
  output logic [5:0] out_boundary,
  output logic [5:0] out_tagged_members,
  output logic [11:0] out_vid,
  output logic [1:0] egress_tag_control
);
  logic [9:0] ctrl_r;
  logic [5:0] dmap_r;
  logic [3:0] dgrp_r;
  logic [5:0] etc_r;
  logic [vic_pkg::NPORT-1:0][11:0] port_default_vid_r;
  logic [vic_pkg::NFILT-1:0][31:0] filt_r;
  logic [15:0] viol_cnt_r;
  logic [15:0] drop_cnt_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic out_valid_r;
  logic out_drop_r;
  logic out_viol_r;
  logic [3:0] out_group_r;
  logic [5:0] out_bnd_r;
  logic [5:0] out_tmem_r;
  logic [11:0] out_vid_r;
  logic [1:0] out_etc_r;

  // Register decode
  wire logic sel_ctrl = paddr == vic_pkg::A_CTRL;
  wire logic sel_defs = paddr == vic_pkg::A_DEFS;
  wire logic sel_etc = paddr == vic_pkg::A_ETC;
  wire logic sel_stat = paddr == vic_pkg::A_STAT;
  wire logic [2:0] pidx = paddr[vic_pkg::IDX_LSB +: 3];
  wire logic [3:0] fidx = paddr[vic_pkg::IDX_LSB +: 4];
  wire logic sel_port_default_vid = (paddr & vic_pkg::M_PORT_DEFAULT_VID) == vic_pkg::A_PORT_DEFAULT_VID
    && pidx < 3'(vic_pkg::NPORT);
  wire logic sel_filt = (paddr & vic_pkg::M_FILT) == vic_pkg::A_FILT;
  wire logic mapped = sel_ctrl | sel_defs | sel_etc | sel_stat | sel_port_default_vid | sel_filt;
  wire logic setup = psel & ~penable;
  wire logic wr_en = psel & penable & pwrite & mapped;
  wire logic [31:0] rd_mux =
    sel_ctrl ? {22'h0, ctrl_r} :
    sel_defs ? {20'h0, dgrp_r, 2'h0, dmap_r} :
    sel_etc ? {26'h0, etc_r} :
    sel_stat ? {drop_cnt_r, viol_cnt_r} :
    sel_port_default_vid ? {20'h0, port_default_vid_r[pidx]} :
    sel_filt ? filt_r[fidx] : 32'h0;

  // Configuration fields
  wire logic tag_vlan_mode_enable = ctrl_r[vic_pkg::B_TAGMODE];
  wire logic replace_null_vid = ctrl_r[vic_pkg::B_RNULL];
  wire logic replace_vid_one = ctrl_r[vic_pkg::B_RONE];
  wire logic replace_all_ones_vid = ctrl_r[vic_pkg::B_RALL];
  wire logic vlan_security_disable = ctrl_r[vic_pkg::B_VSD];
  wire logic force_untagged_input = ctrl_r[vic_pkg::B_FUI];
  wire logic admit_tagged_only = ctrl_r[vic_pkg::B_ATO];
  wire logic vid_match_check = ctrl_r[vic_pkg::B_VCHK];
  wire logic fallback_to_port_grouping = ctrl_r[vic_pkg::B_FALL];
  wire logic ingress_filter_enable = ctrl_r[vic_pkg::B_IFE];

  // VID resolution
  wire logic src_ok = in_src_port < 3'(vic_pkg::NPORT);
  wire logic [11:0] port_default_vid = src_ok ? port_default_vid_r[in_src_port] : 12'h000;
  wire logic is_null = in_tag_vid == vic_pkg::VID_NULL;
  wire logic is_one = in_tag_vid == vic_pkg::VID_ONE;
  wire logic is_all = in_tag_vid == vic_pkg::VID_ALL;
  wire logic replaced = (is_null & replace_null_vid)
    | (is_one & replace_vid_one)
    | (is_all & replace_all_ones_vid);
  // Security and forced-untagged both fall back to the port VID
  wire logic use_port_default_vid = force_untagged_input
    | ~vlan_security_disable
    | ~in_tagged | replaced;
  wire logic [11:0] cmp_vid = use_port_default_vid ? port_default_vid : in_tag_vid;

  // Filter lookup
  logic m_hit;
  logic [3:0] m_idx;
  vic_vid_match u_match (
    .filters(filt_r),
    .vid(cmp_vid),
    .skip_port_filters(fallback_to_port_grouping),
    .hit(m_hit),
    .idx(m_idx)
  );
  wire logic unmatched = tag_vlan_mode_enable & ~m_hit;
  wire logic use_port = ~tag_vlan_mode_enable
    | (unmatched & fallback_to_port_grouping);
  wire logic use_dflt = unmatched & ~fallback_to_port_grouping;
  wire logic [31:0] sel_f = use_port ? filt_r[{1'b0, in_src_port}] : filt_r[m_idx];
  wire logic [3:0] grp = use_dflt ? dgrp_r : vic_pkg::fid_of(sel_f);
  wire logic [5:0] bnd = use_dflt ? dmap_r : vic_pkg::mem_of(sel_f);
  wire logic [5:0] tmem = use_dflt ? 6'h00 : vic_pkg::tmem_of(sel_f);
  wire logic [7:0] bnd_ext = {2'h0, bnd};

  // Violation checks
  wire logic v_all = ~force_untagged_input & ~vlan_security_disable
    & in_tagged & is_all & ~replace_all_ones_vid;
  wire logic v_ato = admit_tagged_only & ~force_untagged_input
    & (~in_tagged | is_null);
  wire logic v_chk = unmatched & vid_match_check;
  wire logic v_ife = ingress_filter_enable & ~bnd_ext[in_src_port];
  wire logic violation = v_all | v_ato | v_chk | v_ife;
  wire logic drop = violation & ~in_cross_vlan;

  logic [1:0] etc_sel;
  vic_egress_tag u_etag (
    .cls(in_class),
    .ovr_valid(tag_override_valid),
    .ovr_tag(tag_override),
    .lrn_hit(lrn_hit),
    .lrn_tag(lrn_tag),
    .ctl_hit(ctl_hit),
    .ctl_tag(ctl_tag),
    .cfg_bridge(etc_r[1:0]),
    .cfg_arp(etc_r[vic_pkg::E_ARP_LSB +: 2]),
    .cfg_igmp(etc_r[vic_pkg::E_IGMP_LSB +: 2]),
    .tag(etc_sel)
  );

  // Counters: an event in the clearing cycle is still counted
  wire logic stat_clr = wr_en & sel_stat;
  wire logic cnt_viol = out_valid_r & out_viol_r;
  wire logic cnt_drop = out_valid_r & out_drop_r;
  wire logic [15:0] viol_cnt_nxt = (stat_clr ? 16'h0 : viol_cnt_r) + {15'h0, cnt_viol};
  wire logic [15:0] drop_cnt_nxt = (stat_clr ? 16'h0 : drop_cnt_r) + {15'h0, cnt_drop};

  // APB slave: zero wait states, data latched in setup
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prdata_r <= 32'h0;
      pslverr_r <= 1'b0;
    end
    else if (setup)
    begin
      prdata_r <= pwrite ? 32'h0 : rd_mux;
      pslverr_r <= ~mapped;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_r <= vic_pkg::CTRL_RST;
      dmap_r <= 6'h00;
      dgrp_r <= 4'h0;
      etc_r <= 6'h00;
    end
    else if (wr_en)
    begin
      if (sel_ctrl)
        ctrl_r <= pwdata[9:0];
      if (sel_defs)
        dmap_r <= pwdata[5:0];
      if (sel_defs)
        dgrp_r <= pwdata[vic_pkg::D_GRP_LSB +: 4];
      if (sel_etc)
        etc_r <= pwdata[5:0];
    end
  end

  // Filter and port VID storage
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      filt_r <= '0;
      port_default_vid_r <= {vic_pkg::NPORT{vic_pkg::PORT_DEFAULT_VID_RST}};
    end
    else if (wr_en)
    begin
      if (sel_filt)
        filt_r[fidx] <= pwdata;
      if (sel_port_default_vid)
        port_default_vid_r[pidx] <= pwdata[11:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      viol_cnt_r <= 16'h0;
      drop_cnt_r <= 16'h0;
    end
    else
    begin
      viol_cnt_r <= viol_cnt_nxt;
      drop_cnt_r <= drop_cnt_nxt;
    end
  end

  // Result stage, one cycle after in_valid
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      out_valid_r <= 1'b0;
    else
      out_valid_r <= in_valid;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      out_drop_r <= 1'b0;
      out_viol_r <= 1'b0;
      out_group_r <= 4'h0;
      out_bnd_r <= 6'h00;
      out_tmem_r <= 6'h00;
      out_vid_r <= 12'h000;
      out_etc_r <= 2'h0;
    end
    else if (in_valid)
    begin
      out_drop_r <= drop;
      out_viol_r <= violation;
      out_group_r <= grp;
      out_bnd_r <= bnd;
      out_tmem_r <= tmem;
      out_vid_r <= cmp_vid;
      out_etc_r <= etc_sel;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = pslverr_r;
  assign out_valid = out_valid_r;
  assign out_drop = out_drop_r;
  assign out_violation = out_viol_r;
  assign out_group = out_group_r;
  assign out_boundary = out_bnd_r;
  assign out_tagged_members = out_tmem_r;
  assign out_vid = out_vid_r;
  assign egress_tag_control = out_etc_r;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  AST_RESULT_NEXT: assert property (in_valid |=> out_valid)
    else $error("result missing one cycle after request");
  AST_PORT_GROUP: assert property (in_valid && !tag_vlan_mode_enable && src_ok
    |=> out_group == $past(vic_pkg::fid_of(filt_r[{1'b0, in_src_port}])))
    else $error("port mode group not from source filter");
  AST_NULL_REPL: assert property (in_valid && in_tagged && is_null && replace_null_vid
    |=> out_vid == $past(port_default_vid))
    else $error("null VID not replaced");
  AST_ONE_REPL: assert property (in_valid && in_tagged && is_one && replace_vid_one
    |=> out_vid == $past(port_default_vid))
    else $error("VID one not replaced");
  AST_ALL_REPL: assert property (in_valid && in_tagged && is_all && replace_all_ones_vid
    |=> out_vid == $past(port_default_vid))
    else $error("all-ones VID not replaced");
  AST_SECURITY: assert property (in_valid && (!vlan_security_disable || force_untagged_input)
    |=> out_vid == $past(port_default_vid))
    else $error("port VID not used under security");
  AST_TAG_ONLY: assert property (in_valid && admit_tagged_only && !force_untagged_input
    && !in_tagged |=> out_violation)
    else $error("untagged packet accepted on tagged-only port");
  AST_VID_CHECK: assert property (in_valid && tag_vlan_mode_enable && vid_match_check
    && !m_hit |=> out_violation)
    else $error("unmatched VID not flagged");
  AST_INGRESS: assert property (in_valid && ingress_filter_enable && src_ok
    |=> out_violation || out_boundary[$past(in_src_port)])
    else $error("source outside boundary accepted");
  AST_DROP: assert property (in_valid ##1 out_violation
    |-> out_drop == !$past(in_cross_vlan))
    else $error("violation drop mismatch");
  AST_OVERRIDE: assert property (in_valid && tag_override_valid
    |=> egress_tag_control == $past(tag_override))
    else $error("override tag not taken");

  COV_PORT_PASS: cover property (in_valid && !tag_vlan_mode_enable ##1 !out_drop);
  COV_TAG_DROP: cover property (in_valid && tag_vlan_mode_enable ##1 out_drop);
  COV_CROSS_KEEP: cover property (in_valid && in_cross_vlan ##1 out_violation && !out_drop);
endmodule : vic_classifier

// ---- common/vic_pkg.sv ----
// Purpose: Shared constants, register map and helpers of the VLAN ingress classifier
// Assumes: 32-bit APB register word, six ports, sixteen filters
// Notes: Filter word holds valid, VID, group, tagged members, members
package vic_pkg;
  localparam int NPORT = 6;
  localparam int NFILT = 16;
  localparam int FIRST_TAG_FILT = 6;
  localparam int IDX_LSB = 2;
  localparam logic [11:0] VID_NULL = 12'h000;
  localparam logic [11:0] VID_ONE = 12'h001;
  localparam logic [11:0] VID_ALL = 12'hFFF;
  localparam logic [11:0] PORT_DEFAULT_VID_RST = 12'h001;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_DEFS = 8'h04;
  localparam logic [7:0] A_ETC = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [7:0] A_PORT_DEFAULT_VID = 8'h40;
  localparam logic [7:0] M_PORT_DEFAULT_VID = 8'hE0;
  localparam logic [7:0] A_FILT = 8'h80;
  localparam logic [7:0] M_FILT = 8'hC0;
  localparam int B_TAGMODE = 0;
  localparam int B_RNULL = 1;
  localparam int B_RONE = 2;
  localparam int B_RALL = 3;
  localparam int B_VSD = 4;
  localparam int B_FUI = 5;
  localparam int B_ATO = 6;
  localparam int B_VCHK = 7;
  localparam int B_FALL = 8;
  localparam int B_IFE = 9;
  localparam logic [9:0] CTRL_RST = 10'h090;
  localparam int D_GRP_LSB = 8;
  localparam int E_ARP_LSB = 2;
  localparam int E_IGMP_LSB = 4;
  localparam int F_TAG_LSB = 6;
  localparam int F_FID_LSB = 12;
  localparam int F_VID_LSB = 16;
  localparam int F_VLD = 31;
  typedef enum logic [1:0] {
    VIC_CLS_OTHER = 2'h0,
    VIC_CLS_BRIDGE = 2'h1,
    VIC_CLS_ARP = 2'h2,
    VIC_CLS_IGMP = 2'h3
  } vic_cls_t;
  function automatic logic [5:0] mem_of(input logic [31:0] f);
    mem_of = f[5:0];
  endfunction : mem_of
  function automatic logic [5:0] tmem_of(input logic [31:0] f);
    tmem_of = f[F_TAG_LSB +: 6];
  endfunction : tmem_of
  function automatic logic [3:0] fid_of(input logic [31:0] f);
    fid_of = f[F_FID_LSB +: 4];
  endfunction : fid_of
  function automatic logic [11:0] vid_of(input logic [31:0] f);
    vid_of = f[F_VID_LSB +: 12];
  endfunction : vid_of
endpackage : vic_pkg

// ---- logic/vic_vid_match.sv ----
// Purpose: Compare a VID against all valid VLAN filters
// Assumes: Lowest matching index wins
// Notes: With port fallback the first six filters serve ports only
`timescale 1ns/1ps
module vic_vid_match (
  input wire logic [vic_pkg::NFILT-1:0][31:0] filters,
  input wire logic [11:0] vid,
  input wire logic skip_port_filters,
  output logic hit,
  output logic [3:0] idx
);
  logic [vic_pkg::NFILT-1:0] eq;
  genvar g;
  generate
    for (g = 0; g < vic_pkg::NFILT; g++)
    begin : g_cmp
      assign eq[g] = filters[g][vic_pkg::F_VLD] && vic_pkg::vid_of(filters[g]) == vid
        && !(skip_port_filters && g < vic_pkg::FIRST_TAG_FILT);
    end
  endgenerate
  always_comb
  begin
    hit = 1'b0;
    idx = 4'h0;
    for (int i = vic_pkg::NFILT - 1; i >= 0; i--)
    begin
      if (eq[i])
      begin
        hit = 1'b1;
        idx = 4'(i);
      end
    end
  end
endmodule : vic_vid_match

// ---- logic/vic_egress_tag.sv ----
// Purpose: Pick the 2-bit egress tag control by packet class
// Assumes: Lookup hits and override come from same-clock logic
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/1ps
module vic_egress_tag (
  input wire vic_pkg::vic_cls_t cls,
  input wire logic ovr_valid,
  input wire logic [1:0] ovr_tag,
  input wire logic lrn_hit,
  input wire logic [1:0] lrn_tag,
  input wire logic ctl_hit,
  input wire logic [1:0] ctl_tag,
  input wire logic [1:0] cfg_bridge,
  input wire logic [1:0] cfg_arp,
  input wire logic [1:0] cfg_igmp,
  output logic [1:0] tag
);
  always_comb
  begin
    tag = 2'h0;
    if (ovr_valid)
      tag = ovr_tag;
    else
      unique case (cls)
        vic_pkg::VIC_CLS_BRIDGE: tag = lrn_hit ? lrn_tag : ctl_hit ? ctl_tag : cfg_bridge;
        vic_pkg::VIC_CLS_ARP: tag = cfg_arp;
        vic_pkg::VIC_CLS_IGMP: tag = cfg_igmp;
        vic_pkg::VIC_CLS_OTHER: tag = lrn_hit ? lrn_tag : 2'h0;
      endcase
  end
endmodule : vic_egress_tag

// ---- verification/vic_rx_peer.sv ----
// Purpose: Model of the receive ports and lookup engine that feed the classifier
// Assumes: One packet per send call; fields are only meaningful in the in_valid cycle
// Notes: Idle fields show inverted last values, tag values a fixed 6'h31, so stale data is never trusted
`timescale 1ns/1ps
module vic_rx_peer (
  input wire logic ref_clk,
  output logic in_valid,
  output logic [2:0] in_src_port,
  output logic in_tagged,
  output logic [11:0] in_tag_vid,
  output vic_pkg::vic_cls_t in_class,
  output logic in_cross_vlan,
  output logic tag_override_valid,
  output logic [1:0] tag_override,
  output logic lrn_hit,
  output logic [1:0] lrn_tag,
  output logic ctl_hit,
  output logic [1:0] ctl_tag
);
  initial
  begin
    in_valid = 1'b0;
    {in_src_port, in_tagged, in_tag_vid, in_cross_vlan} = '0;
    in_class = vic_pkg::VIC_CLS_OTHER;
    {tag_override_valid, tag_override, lrn_hit, lrn_tag, ctl_hit, ctl_tag} = '0;
  end
  // Each source carries its own tag value so the priority order shows at the output
  task automatic send(input logic [2:0] sp, input logic tg, input logic [11:0] vid,
    input vic_pkg::vic_cls_t cls, input logic cx, input logic [2:0] hits);
    @(posedge ref_clk);
    in_valid <= 1'b1;
    in_src_port <= sp;
    in_tagged <= tg;
    in_tag_vid <= vid;
    in_class <= cls;
    in_cross_vlan <= cx;
    {tag_override_valid, lrn_hit, ctl_hit} <= hits;
    tag_override <= 2'h3;
    lrn_tag <= 2'h1;
    ctl_tag <= 2'h2;
    @(posedge ref_clk);
    in_valid <= 1'b0;
    in_src_port <= ~sp;
    in_tagged <= ~tg;
    in_tag_vid <= ~vid;
    in_class <= vic_pkg::vic_cls_t'(~cls);
    in_cross_vlan <= ~cx;
    {tag_override_valid, lrn_hit, ctl_hit} <= ~hits;
    {tag_override, lrn_tag, ctl_tag} <= 6'h31;
  endtask : send
endmodule : vic_rx_peer

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for the VLAN ingress classifier
// Assumes: Zero-wait APB slave; one registered result per packet
// Notes: Filter 2 serves port mode, filter 7 serves VID 0x123 in tag mode
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic in_valid, in_tagged, in_cross_vlan, tag_override_valid, lrn_hit, ctl_hit;
  logic [2:0] in_src_port;
  logic [11:0] in_tag_vid, out_vid;
  vic_pkg::vic_cls_t in_class;
  logic [1:0] tag_override, lrn_tag, ctl_tag, egress_tag_control;
  logic out_valid, out_drop, out_violation;
  logic [3:0] out_group;
  logic [5:0] out_boundary, out_tagged_members;
  logic [11:0] rvid [3] = '{12'h000, 12'h001, 12'hFFF};
  // Class, override, learning hit, control hit, expected tag control
  // Bridge, ARP and IGMP defaults differ from each other and from zero
  logic [6:0] etab [11] = '{7'b0011111, 7'b0001101, 7'b0000100, 7'b0111111,
    7'b0101101, 7'b0100110, 7'b0100011, 7'b1010011, 7'b1001110, 7'b1110011, 7'b1101101};
  int n_fail, n_checks;

  vic_classifier dut (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .in_valid, .in_src_port, .in_tagged, .in_tag_vid, .in_class,
    .in_cross_vlan, .tag_override_valid, .tag_override, .lrn_hit, .lrn_tag, .ctl_hit,
    .ctl_tag, .out_valid, .out_drop, .out_violation, .out_group, .out_boundary,
    .out_tagged_members, .out_vid, .egress_tag_control);
  vic_rx_peer peer (.ref_clk, .in_valid, .in_src_port, .in_tagged, .in_tag_vid, .in_class,
    .in_cross_vlan, .tag_override_valid, .tag_override, .lrn_hit, .lrn_tag, .ctl_hit,
    .ctl_tag);

  always #5 ref_clk = ~ref_clk;

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (i == 20)
    begin
      n_fail++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic xerr);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, xerr});
  endtask : rdchk

  // Waits for the one-cycle result pulse; a missing pulse ends the run
  task automatic pkt(input logic [2:0] sp, input logic tg, input logic [11:0] vid,
    input vic_pkg::vic_cls_t cls, input logic cx, input logic [2:0] hits);
    int i;
    peer.send(sp, tg, vid, cls, cx, hits);
    for (i = 0; i < 4; i++)
    begin
      #1;
      if (out_valid === 1'b1) break;
      @(posedge ref_clk);
    end
    if (i == 4)
    begin
      n_fail++;
      tally_and_finish();
    end
  endtask : pkt

  // Expected word: {0, 0, drop, violation, group, 0, 0, boundary, vid}
  task automatic pk(input logic [2:0] sp, input logic tg, input logic [11:0] vid,
    input logic cx, input logic [27:0] exp);
    pkt(sp, tg, vid, vic_pkg::VIC_CLS_OTHER, cx, 3'h0);
    chk({6'h0, out_drop, out_violation, out_group, 2'h0, out_boundary, out_vid}, {4'h0, exp});
  endtask : pk

  initial
  begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    n_fail = 0;
    n_checks = 0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    rdchk(8'h00, 32'h0000_0090, 1'b0);
    rdchk(8'h40, 32'h0000_0001, 1'b0);
    rdchk(8'h10, 32'h0000_0000, 1'b1);
    apb(1'b1, 8'h88, 32'h0000_5004);
    apb(1'b1, 8'h9C, 32'h8123_933F);
    apb(1'b1, 8'h04, 32'h0000_0A15);
    apb(1'b1, 8'h00, 32'h0000_0290);
    pk(3'h2, 1'b0, 12'h000, 1'b0, 28'h0_5_04_001);
    pk(3'h3, 1'b0, 12'h000, 1'b0, 28'h3_0_00_001);
    pk(3'h3, 1'b0, 12'h000, 1'b1, 28'h1_0_00_001);
    apb(1'b1, 8'h40, 32'h0000_0123);
    apb(1'b1, 8'h00, 32'h0000_0091);
    pk(3'h1, 1'b1, 12'h123, 1'b0, 28'h0_9_3F_123);
    pk(3'h1, 1'b1, 12'h456, 1'b0, 28'h3_A_15_456);
    apb(1'b1, 8'h00, 32'h0000_0011);
    pk(3'h1, 1'b1, 12'h456, 1'b0, 28'h0_A_15_456);
    apb(1'b1, 8'h00, 32'h0000_0111);
    pk(3'h2, 1'b1, 12'h456, 1'b0, 28'h0_5_04_456);
    apb(1'b1, 8'h00, 32'h0000_009F);
    for (int i = 0; i < 3; i++)
    begin
      pk(3'h0, 1'b1, rvid[i], 1'b0, 28'h0_9_3F_123);
    end
    apb(1'b1, 8'h00, 32'h0000_0081);
    pk(3'h0, 1'b1, 12'hFFF, 1'b0, 28'h3_9_3F_123);
    pk(3'h0, 1'b1, 12'h456, 1'b0, 28'h0_9_3F_123);
    apb(1'b1, 8'h00, 32'h0000_0051);
    pk(3'h0, 1'b0, 12'h789, 1'b0, 28'h3_9_3F_123);
    pk(3'h1, 1'b1, 12'h000, 1'b0, 28'h3_A_15_000);
    apb(1'b1, 8'h00, 32'h0000_0071);
    pk(3'h0, 1'b0, 12'h789, 1'b0, 28'h0_9_3F_123);
    pk(3'h0, 1'b1, 12'h456, 1'b0, 28'h0_9_3F_123);
    apb(1'b1, 8'h08, 32'h0000_001B);
    apb(1'b1, 8'h00, 32'h0000_0091);
    for (int i = 0; i < 11; i++)
    begin
      pkt(3'h1, 1'b1, 12'h123, vic_pkg::vic_cls_t'(etab[i][6:5]), 1'b0, etab[i][4:2]);
      chk(32'(egress_tag_control), 32'(etab[i][1:0]));
      chk(32'(out_tagged_members), 32'h0000_000C);
    end
    // Six violations so far, five of them dropped
    rdchk(8'h0C, 32'h0005_0006, 1'b0);
    apb(1'b1, 8'h0C, 32'h0000_0000);
    rdchk(8'h0C, 32'h0000_0000, 1'b0);
    tally_and_finish();
  end
endmodule : tb_top
